// file: gpei_map.vh
`ifndef GPEI_MAP_VH
`define GPEI_MAP_VH

// Byte offsets of the registers; each of the first seven groups holds one word per port.
`define GPEI_OFF_DATA   8'h00
`define GPEI_OFF_SEL    8'h0C
`define GPEI_OFF_DIR    8'h18
`define GPEI_OFF_INP    8'h24
`define GPEI_OFF_IEN    8'h30
`define GPEI_OFF_IFG    8'h3C
`define GPEI_OFF_LAT    8'h48
`define GPEI_OFF_EDGE   8'h54
`define GPEI_OFF_CFG    8'h58
`define GPEI_OFF_BITOP  8'h5C
`define GPEI_OFF_STATUS 8'h60

// Field positions in the edge configuration register.
`define GPEI_EDGE_P0    0
`define GPEI_EDGE_P1    1
`define GPEI_EDGE_P2    2
`define GPEI_EDGE_PADC  6

// Field positions in the group configuration register.
`define GPEI_CFG_GEN_LO 0
`define GPEI_CFG_GEN_HI 2
`define GPEI_CFG_PD_LO  4
`define GPEI_CFG_PD_HI  6

// Field positions in the bit operation register.
`define GPEI_BIT_IDX_LO 0
`define GPEI_BIT_IDX_HI 2
`define GPEI_BIT_PRT_LO 3
`define GPEI_BIT_PRT_HI 4
`define GPEI_BIT_VAL    8

// Reset values.
`define GPEI_RST_SEL    21'h000000
`define GPEI_RST_DIR    21'h000000
`define GPEI_RST_INP    21'h000000
`define GPEI_RST_IEN    21'h000000
`define GPEI_RST_LAT    21'h000000
`define GPEI_RST_EDGE   8'h00
`define GPEI_RST_CFG    8'h00

// Pins of the second port with no pull resistors.
`define GPEI_NO_PULL    21'h000300

`endif

// file: gpei_gpio.v
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpei_map.vh"

// Function
// - 21 pins, each GPIO or peripheral
// - Two 8-bit ports and one 5-bit port
// - Port data reachable by byte and bit
// - Function select; reset gives GPIO inputs
// - Direction bit 1 makes an output
// - Data read returns sampled pin levels
// - Bit operations modify the output latch
// - Inputs pullup, pulldown or three-state; pullup
// - Input mode 1 gives three-state
// - Second port pins 0,1 have no pulls
// - Peripheral pins have pulls disabled
// - Sleep modes freeze pin mode and output
// - Interrupt edge rising or falling per port
// - One group enable per port
// - Per-pin enables, any pin configuration
// - Edge sets flag regardless of enable
// - Writing 0 clears a flag
// - Port request is level of flags
// - First two ports pulse a DMA trigger
// - Pin events wake from all sleep modes
module gpei_gpio #(
  parameter NPIN = 21
) (
  input  wire              CLK,
  input  wire              RST_N,
  input  wire              HSEL,
  input  wire [31:0]       HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire              HREADYOUT,
  output wire              HRESP,
  output reg  [31:0]       HRDATA,
  input  wire [NPIN-1:0]   PIN_IN,
  output reg  [NPIN-1:0]   PIN_OUT,
  output reg  [NPIN-1:0]   PIN_OE,
  output reg  [NPIN-1:0]   PIN_PULLUP_EN,
  output reg  [NPIN-1:0]   PIN_PULLDOWN_EN,
  input  wire [NPIN-1:0]   PERIPH_OUT,
  input  wire [NPIN-1:0]   PERIPH_OE,
  output wire [NPIN-1:0]   PERIPH_IN,
  input  wire [2:0]        SLEEP_MODE,
  output reg               WAKE,
  output reg  [2:0]        PORT_IRQ,
  output reg  [1:0]        DMA_TRIG,
  output reg               PAD_COMP
);

  reg  [NPIN-1:0] sel_q;
  reg  [NPIN-1:0] dir_q;
  reg  [NPIN-1:0] inp_q;
  reg  [NPIN-1:0] ien_q;
  reg  [NPIN-1:0] ifg_q;
  reg  [NPIN-1:0] ifg_d;
  reg  [NPIN-1:0] lat_q;
  reg  [NPIN-1:0] lat_d;
  reg  [7:0]      edge_q;
  reg  [7:0]      cfg_q;
  reg  [NPIN-1:0] sync1_q;
  reg  [NPIN-1:0] sync2_q;
  reg  [NPIN-1:0] prev_q;
  reg  [2:0]      arm_q;
  reg  [7:0]      addr_q;
  reg             wr_q;
  reg             act_q;
  reg  [31:0]     rdata_d;
  wire            take;
  wire [7:0]      addr_w;
  wire            wen;
  wire [7:0]      wbyte;
  wire [NPIN-1:0] pol;
  wire [NPIN-1:0] rise;
  wire [NPIN-1:0] fall;
  wire [NPIN-1:0] ev;
  wire [NPIN-1:0] pending;
  wire [NPIN-1:0] pd_sel;
  wire [2:0]      req;
  wire            hold;
  wire [1:0]      bit_port;
  wire [2:0]      bit_idx;
  wire [4:0]      bit_pin;

  // Byte lane of a port from a pin vector; the third port has five bits.
  function [7:0] getb;
    input [20:0] v;
    input [1:0]  p;
    begin
      case (p)
        2'h0:    getb = v[7:0];
        2'h1:    getb = v[15:8];
        default: getb = {3'h0, v[20:16]};
      endcase
    end
  endfunction

  // Replace a port's lane within a pin vector.
  function [20:0] putb;
    input [20:0] v;
    input [1:0]  p;
    input [7:0]  b;
    begin
      putb = v;
      case (p)
        2'h0:    putb[7:0] = b;
        2'h1:    putb[15:8] = b;
        default: putb[20:16] = b[4:0];
      endcase
    end
  endfunction

  // True when the address selects one of the three words of a group.
  function ingrp;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] d;
    begin
      d = a - b;
      ingrp = (a >= b) && (d[7:4] == 4'h0) && (d[3:2] != 2'h3) && (d[1:0] == 2'h0);
    end
  endfunction

  // Port index of an address within a group.
  function [1:0] gidx;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] d;
    begin
      d = a - b;
      gidx = d[3:2];
    end
  endfunction

  // Zero-wait slave; every answer is OKAY.
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  assign take   = HSEL & HTRANS[1] & HREADY;
  assign addr_w = (HADDR[31:8] == 24'h000000) ? HADDR[7:0] : 8'hFF;
  assign wen    = act_q & wr_q;
  assign wbyte  = HWDATA[7:0];

  always @(posedge CLK) begin
    if (!RST_N) begin
      addr_q <= 8'hFF;
      wr_q   <= 1'b0;
      act_q  <= 1'b0;
      HRDATA <= 32'h00000000;
    end else begin
      act_q <= take;
      if (take) begin
        addr_q <= addr_w;
        wr_q   <= HWRITE;
      end
      HRDATA <= (take && !HWRITE) ? rdata_d : 32'h00000000;
    end
  end

  // Pins are synchronised before readback and edge detection.
  always @(posedge CLK) begin
    if (!RST_N) begin
      sync1_q <= {NPIN{1'b0}};
      sync2_q <= {NPIN{1'b0}};
      prev_q  <= {NPIN{1'b0}};
      arm_q   <= 3'h0;
    end else begin
      arm_q   <= {arm_q[1:0], 1'b1};
      sync1_q <= PIN_IN;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign PERIPH_IN = sync2_q;

  // Edge selection per port; 1 selects the falling edge.
  assign pol  = {{5{edge_q[`GPEI_EDGE_P2]}}, {8{edge_q[`GPEI_EDGE_P1]}}, {8{edge_q[`GPEI_EDGE_P0]}}};
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  // Events wait until the pipeline holds real pin levels, so a pulled-up pin gives no false edge after reset.
  assign ev   = {NPIN{arm_q[2]}} & ((pol & fall) | (~pol & rise));

  // Flags set on every selected edge whatever the enables; an event beats a clear.
  always @* begin
    ifg_d = ifg_q;
    if (wen && ingrp(addr_q, `GPEI_OFF_IFG)) begin
      ifg_d = ifg_q & putb({NPIN{1'b1}}, gidx(addr_q, `GPEI_OFF_IFG), wbyte);
    end
    ifg_d = ifg_d | ev;
  end

  assign bit_idx  = HWDATA[`GPEI_BIT_IDX_HI:`GPEI_BIT_IDX_LO];
  assign bit_port = HWDATA[`GPEI_BIT_PRT_HI:`GPEI_BIT_PRT_LO];
  assign bit_pin  = {bit_port, 3'h0} + {2'h0, bit_idx};

  // Byte writes load a port latch; a bit operation reads the latch, not the pin.
  always @* begin
    lat_d = lat_q;
    if (wen && ingrp(addr_q, `GPEI_OFF_DATA)) begin
      lat_d = putb(lat_q, gidx(addr_q, `GPEI_OFF_DATA), wbyte);
    end else if (wen && ingrp(addr_q, `GPEI_OFF_LAT)) begin
      lat_d = putb(lat_q, gidx(addr_q, `GPEI_OFF_LAT), wbyte);
    end else if (wen && addr_q == `GPEI_OFF_BITOP && bit_port != 2'h3 && bit_pin < 5'd21) begin
      lat_d[bit_pin] = HWDATA[`GPEI_BIT_VAL];
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      sel_q  <= `GPEI_RST_SEL;
      dir_q  <= `GPEI_RST_DIR;
      inp_q  <= `GPEI_RST_INP;
      ien_q  <= `GPEI_RST_IEN;
      ifg_q  <= {NPIN{1'b0}};
      lat_q  <= `GPEI_RST_LAT;
      edge_q <= `GPEI_RST_EDGE;
      cfg_q  <= `GPEI_RST_CFG;
    end else begin
      ifg_q <= ifg_d;
      lat_q <= lat_d;
      if (wen && ingrp(addr_q, `GPEI_OFF_SEL)) begin
        sel_q <= putb(sel_q, gidx(addr_q, `GPEI_OFF_SEL), wbyte);
      end
      if (wen && ingrp(addr_q, `GPEI_OFF_DIR)) begin
        dir_q <= putb(dir_q, gidx(addr_q, `GPEI_OFF_DIR), wbyte);
      end
      if (wen && ingrp(addr_q, `GPEI_OFF_INP)) begin
        inp_q <= putb(inp_q, gidx(addr_q, `GPEI_OFF_INP), wbyte);
      end
      if (wen && ingrp(addr_q, `GPEI_OFF_IEN)) begin
        ien_q <= putb(ien_q, gidx(addr_q, `GPEI_OFF_IEN), wbyte);
      end
      if (wen && addr_q == `GPEI_OFF_EDGE) begin
        edge_q <= {1'b0, wbyte[`GPEI_EDGE_PADC], 3'h0, wbyte[2:0]};
      end
      if (wen && addr_q == `GPEI_OFF_CFG) begin
        cfg_q <= {1'b0, wbyte[`GPEI_CFG_PD_HI:`GPEI_CFG_PD_LO], 1'b0, wbyte[`GPEI_CFG_GEN_HI:`GPEI_CFG_GEN_LO]};
      end
    end
  end

  // Read mux, evaluated in the address phase and registered.
  always @* begin
    rdata_d = 32'h00000000;
    if (ingrp(addr_w, `GPEI_OFF_DATA)) begin
      rdata_d[7:0] = getb(sync2_q, gidx(addr_w, `GPEI_OFF_DATA));
    end else if (ingrp(addr_w, `GPEI_OFF_SEL)) begin
      rdata_d[7:0] = getb(sel_q, gidx(addr_w, `GPEI_OFF_SEL));
    end else if (ingrp(addr_w, `GPEI_OFF_DIR)) begin
      rdata_d[7:0] = getb(dir_q, gidx(addr_w, `GPEI_OFF_DIR));
    end else if (ingrp(addr_w, `GPEI_OFF_INP)) begin
      rdata_d[7:0] = getb(inp_q, gidx(addr_w, `GPEI_OFF_INP));
    end else if (ingrp(addr_w, `GPEI_OFF_IEN)) begin
      rdata_d[7:0] = getb(ien_q, gidx(addr_w, `GPEI_OFF_IEN));
    end else if (ingrp(addr_w, `GPEI_OFF_IFG)) begin
      rdata_d[7:0] = getb(ifg_q, gidx(addr_w, `GPEI_OFF_IFG));
    end else if (ingrp(addr_w, `GPEI_OFF_LAT)) begin
      rdata_d[7:0] = getb(lat_q, gidx(addr_w, `GPEI_OFF_LAT));
    end else if (addr_w == `GPEI_OFF_EDGE) begin
      rdata_d[7:0] = edge_q;
    end else if (addr_w == `GPEI_OFF_CFG) begin
      rdata_d[7:0] = cfg_q;
    end else if (addr_w == `GPEI_OFF_STATUS) begin
      rdata_d[7:0] = {1'b0, SLEEP_MODE, 1'b0, PORT_IRQ};
    end
  end

  // Port request is a plain level of enabled flags under the group enable.
  assign pending = ifg_q & ien_q;
  assign req[0]  = cfg_q[`GPEI_CFG_GEN_LO] & (|pending[7:0]);
  assign req[1]  = cfg_q[`GPEI_CFG_GEN_LO + 1] & (|pending[15:8]);
  assign req[2]  = cfg_q[`GPEI_CFG_GEN_HI] & (|pending[20:16]);
  assign hold    = |SLEEP_MODE;
  assign pd_sel  = {{5{cfg_q[`GPEI_CFG_PD_HI]}}, {8{cfg_q[`GPEI_CFG_PD_LO + 1]}}, {8{cfg_q[`GPEI_CFG_PD_LO]}}};

  always @(posedge CLK) begin
    if (!RST_N) begin
      PORT_IRQ <= 3'h0;
      DMA_TRIG <= 2'h0;
      WAKE     <= 1'b0;
      PAD_COMP <= 1'b0;
    end else begin
      PORT_IRQ <= req;
      DMA_TRIG <= {|ev[15:8], |ev[7:0]};
      WAKE     <= hold & (|req);
      PAD_COMP <= edge_q[`GPEI_EDGE_PADC];
    end
  end

  // Pad controls; frozen while any sleep mode is active.
  always @(posedge CLK) begin
    if (!RST_N) begin
      PIN_OUT         <= {NPIN{1'b0}};
      PIN_OE          <= {NPIN{1'b0}};
      PIN_PULLUP_EN   <= ~`GPEI_NO_PULL;
      PIN_PULLDOWN_EN <= {NPIN{1'b0}};
    end else if (!hold) begin
      PIN_OUT         <= (sel_q & PERIPH_OUT) | (~sel_q & lat_q);
      PIN_OE          <= (sel_q & PERIPH_OE) | (~sel_q & dir_q);
      PIN_PULLUP_EN   <= ~sel_q & ~dir_q & ~inp_q & ~pd_sel & ~`GPEI_NO_PULL;
      PIN_PULLDOWN_EN <= ~sel_q & ~dir_q & ~inp_q & pd_sel & ~`GPEI_NO_PULL;
    end
  end

endmodule // gpei_gpio
`default_nettype wire

// file: gpei_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gpei_chk #(parameter NPIN = 21) (
  input wire logic            CLK,
  input wire logic            RST_N,
  input wire logic            HSEL,
  input wire logic [1:0]      HTRANS,
  input wire logic            HWRITE,
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PIN_PULLUP_EN,
  input wire logic [NPIN-1:0] PIN_PULLDOWN_EN,
  input wire logic [2:0]      SLEEP_MODE,
  input wire logic            WAKE,
  input wire logic [2:0]      PORT_IRQ,
  input wire logic [1:0]      DMA_TRIG
);
  logic [NPIN-1:0] s1_q, s2_q, s3_q;
  wire             wr = HSEL && HTRANS[1] && HWRITE;
  // Mirror of the input synchroniser, so events can be traced to their pin change.
  always @(posedge CLK) begin
    s1_q <= PIN_IN;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  pull_rst_a: assert property ($rose(RST_N) |-> PIN_PULLUP_EN == 21'h1FFCFF && PIN_OE == 21'h0)
    else $error("reset pad state wrong");
  no_pull_a: assert property ((PIN_PULLUP_EN[9:8] | PIN_PULLDOWN_EN[9:8]) == 2'h0)
    else $error("pull on pins 8 or 9");
  pull_excl_a: assert property ((PIN_PULLUP_EN & PIN_PULLDOWN_EN) == 21'h0)
    else $error("pullup and pulldown together");
  sleep_hold_a: assert property (SLEEP_MODE != 3'h0 |=> $stable(PIN_OUT) && $stable(PIN_OE))
    else $error("pads moved in sleep");
  dma0_cause_a: assert property (DMA_TRIG[0] |-> $past(s2_q[7:0] != s3_q[7:0], 1))
    else $error("port0 trigger without pin change");
  dma1_cause_a: assert property (DMA_TRIG[1] |-> $past(s2_q[15:8] != s3_q[15:8], 1))
    else $error("port1 trigger without pin change");
  irq_fall_a: assert property ($fell(PORT_IRQ[0]) |-> $past(wr, 3))
    else $error("port0 request fell without write");
  irq_rise_a: assert property ($rose(PORT_IRQ[1]) |-> $past(s2_q[15:8] != s3_q[15:8], 2) || $past(wr, 3))
    else $error("port1 request rose without cause");
  wake_cond_a: assert property (WAKE |-> PORT_IRQ != 3'h0 && $past(SLEEP_MODE) != 3'h0)
    else $error("wake without sleep and request");
  cover property (DMA_TRIG[1]);
  cover property (WAKE);
  cover property ($fell(PORT_IRQ[0]));
endmodule // gpei_chk

bind gpei_gpio gpei_chk #(.NPIN(NPIN)) u_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP_EN(PIN_PULLUP_EN),
  .PIN_PULLDOWN_EN(PIN_PULLDOWN_EN), .SLEEP_MODE(SLEEP_MODE), .WAKE(WAKE), .PORT_IRQ(PORT_IRQ),
  .DMA_TRIG(DMA_TRIG));
`default_nettype wire

// file: gpei_pins.sv
`timescale 1ns/1ps
`default_nettype none
module gpei_pins (
  input  wire logic        clk,
  input  wire logic [20:0] pin_out,
  input  wire logic [20:0] pin_oe,
  input  wire logic [20:0] pull_up,
  input  wire logic [20:0] pull_dn,
  input  wire logic [20:0] ext_en,
  input  wire logic [20:0] ext_val,
  output wire logic [20:0] pin_in
);
  logic [20:0] flt_q = 21'h0AAAAA;
  // An undriven, unpulled pad toggles so that a read of it never looks settled.
  always @(posedge clk) flt_q <= ~flt_q;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_up | (~pull_dn & flt_q)));
endmodule // gpei_pins
`default_nettype wire

// file: tb_gpio_ports_with_edge_interrupts.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpei_map.vh"
module tb_gpio_ports_with_edge_interrupts;
  logic        CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  SLEEP_MODE = 3'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd_q, rd;
  logic [20:0] ext_val = 21'h0, ext_en = 21'h1FFFFF;
  wire         HREADYOUT, WAKE, HRESP, PAD_COMP;
  wire [31:0]  HRDATA;
  wire [20:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP_EN, PIN_PULLDOWN_EN;
  wire [2:0]   PORT_IRQ;
  wire [1:0]   DMA_TRIG;
  int          n_fail = 0, n_checks = 0, cyc = 0, n_dma = 0, k;

  gpei_gpio u_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_PULLDOWN_EN(PIN_PULLDOWN_EN), .PERIPH_OUT(21'h0),
    .PERIPH_OE(21'h0), .PERIPH_IN(), .SLEEP_MODE(SLEEP_MODE), .WAKE(WAKE), .PORT_IRQ(PORT_IRQ),
    .DMA_TRIG(DMA_TRIG), .PAD_COMP(PAD_COMP));
  gpei_pins u_pins (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_up(PIN_PULLUP_EN),
    .pull_dn(PIN_PULLDOWN_EN), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN));

  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    rd_q <= HRDATA;
    cyc <= cyc + 1;
    if (DMA_TRIG[1] === 1'b1) n_dma <= n_dma + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    @(negedge CLK);
    rd = rd_q;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, exp);
  endtask
  task automatic wt;
    repeat (6) @(negedge CLK);
  endtask
  task automatic drv(input logic [20:0] v);
    @(posedge CLK);
    ext_val <= v;
    wt();
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    wt();
    chk("pullup", PIN_PULLUP_EN, 32'h1FFCFF);
    chk("oe", PIN_OE, 32'h0);
    for (int i = 0; i < 12; i++) rdc(8'(8'h0C + 4 * i), 32'h0);
    drv(21'h05A5C3);
    for (int p = 0; p < 3; p++) rdc(8'(4 * p), {24'h0, 8'(21'h05A5C3 >> (8 * p))});
    bus(1'b1, `GPEI_OFF_DIR, 32'hFF);
    bus(1'b1, `GPEI_OFF_DATA, 32'h3C);
    wt();
    chk("oe", PIN_OE[7:0], 32'hFF);
    rdc(`GPEI_OFF_DATA, 32'h3C);
    bus(1'b1, `GPEI_OFF_DIR, 32'h02);
    bus(1'b1, `GPEI_OFF_BITOP, 32'h101);
    rdc(`GPEI_OFF_LAT, 32'h3E);
    wt();
    rdc(`GPEI_OFF_DATA, 32'hC3);
    bus(1'b1, `GPEI_OFF_INP, 32'h0F);
    bus(1'b1, `GPEI_OFF_CFG, 32'h10);
    wt();
    chk("pulldown", PIN_PULLDOWN_EN[7:0], 32'hF0);
    bus(1'b1, `GPEI_OFF_SEL, 32'hC0);
    wt();
    chk("pulldown", PIN_PULLDOWN_EN[7:0], 32'h30);
    bus(1'b1, `GPEI_OFF_CFG, 32'h03);
    bus(1'b1, `GPEI_OFF_EDGE, 32'h41);
    rdc(`GPEI_OFF_EDGE, 32'h41);
    chk("pad_comp", PAD_COMP, 32'h1);
    chk("hresp", HRESP, 32'h0);
    bus(1'b1, `GPEI_OFF_IEN, 32'h02);
    bus(1'b1, `GPEI_OFF_IEN + 8'h4, 32'h02);
    for (int p = 0; p < 3; p++) bus(1'b1, 8'(`GPEI_OFF_IFG + 4 * p), 32'h0);
    wt();
    k = n_dma;
    drv(21'h05AFC3);
    rdc(`GPEI_OFF_IFG + 8'h4, 32'h0A);
    chk("irq", PORT_IRQ, 32'h2);
    chk("dma", n_dma - k, 32'h1);
    bus(1'b1, `GPEI_OFF_DATA, 32'h3C);
    wt();
    rdc(`GPEI_OFF_IFG, 32'h02);
    chk("irq", PORT_IRQ, 32'h3);
    bus(1'b1, `GPEI_OFF_IFG + 8'h4, 32'hFD);
    wt();
    rdc(`GPEI_OFF_IFG + 8'h4, 32'h08);
    chk("irq", PORT_IRQ, 32'h1);
    bus(1'b1, `GPEI_OFF_CFG, 32'h02);
    wt();
    chk("irq", PORT_IRQ, 32'h0);
    for (int m = 0; m < 3; m++) begin
      @(posedge CLK);
      SLEEP_MODE <= 3'(1 << m);
      ext_val <= 21'h05ADC3;
      bus(1'b1, `GPEI_OFF_DATA, 32'h00);
      drv(21'h05AFC3);
      chk("wake", WAKE, 32'h1);
      chk("out", PIN_OUT[7:0], 32'h3C);
      rdc(`GPEI_OFF_STATUS, 32'(((1 << m) << 4) | 2));
      bus(1'b1, `GPEI_OFF_IFG + 8'h4, 32'h0);
      @(posedge CLK);
      SLEEP_MODE <= 3'h0;
      bus(1'b1, `GPEI_OFF_DATA, 32'h3C);
      wt();
    end
    bus(1'b1, 8'h80, 32'hFF);
    rdc(8'h80, 32'h0);
    stop_test();
  end
endmodule // tb_gpio_ports_with_edge_interrupts
`default_nettype wire
